// ### core/fip_consts.svh
// Offsets, field positions and reset values of the info page decoder
`ifndef FIP_CONSTS_SVH
`define FIP_CONSTS_SVH
`define FIP_OFF_SIGNATURE_LOW_BITS 8'h00
`define FIP_OFF_SIG1 8'h04
`define FIP_OFF_SIG2 8'h08
`define FIP_OFF_SIGNATURE_HIGH_BITS 8'h0c
`define FIP_OFF_SEC 8'h10
`define FIP_OFF_TRIM 8'h14
`define FIP_OFF_WPL 8'h20
`define FIP_OFF_WPH 8'h24
`define FIP_OFF_CPL 8'h30
`define FIP_OFF_CPH 8'h34
`define FIP_OFF_CTRL 8'h40
`define FIP_OFF_STAT 8'h44
`define FIP_IDX_SIGNATURE_LOW_BITS 4'h0
`define FIP_IDX_SIG1 4'h1
`define FIP_IDX_SIG2 4'h2
`define FIP_IDX_SIGNATURE_HIGH_BITS 4'h3
`define FIP_AIDX_HI 5
`define FIP_AIDX_LO 2
`define FIP_IDX_SEC 4'h4
`define FIP_IDX_TRIM 4'h5
`define FIP_IDX_WPL 4'h8
`define FIP_IDX_WPH 4'h9
`define FIP_IDX_CPL 4'hc
`define FIP_IDX_CPH 4'hd
`define FIP_WORD_RESET 32'hffffffff
`define FIP_SEC_BOOT 9
`define FIP_SEC_ERASE 8
`define FIP_SEC_PROG_HI 7
`define FIP_SEC_PROG_LO 4
`define FIP_SEC_FWIPE 3
`define FIP_SEC_SWIPE 2
`define FIP_SEC_TRACE 1
`define FIP_SEC_DEBUG 0
`define FIP_TRIM_MEM_HI 25
`define FIP_TRIM_MEM_LO 16
`define FIP_TRIM_CORE_HI 9
`define FIP_TRIM_CORE_LO 0
`define FIP_ADDR_HALF 19
`define FIP_CHUNK_HI 18
`define FIP_CHUNK_LO 14
`define FIP_QTR_HI 12
`define FIP_QTR_LO 11
`define FIP_CTRL_FREEZE 0
`define FIP_RESP_OKAY 2'h0
`define FIP_RESP_SLVERR 2'h2
`endif

// ### core/fip_pkg.sv
// Types shared by the info page decoder
`default_nettype none
package fip_pkg;
    typedef enum logic [2:0]
    {
        WIPE_IDLE = 3'b000,
        WIPE_FLASH = 3'b001,
        WIPE_SRAM = 3'b010,
        WIPE_DONE = 3'b011
    } fip_wipe_state_t;
endpackage
`default_nettype wire

// ### core/fip_sync2.sv
// Two-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module fip_sync2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output var logic q
);
    logic meta_q;
    always_ff @(posedge clk)
    begin
        meta_q <= rst ? 1'b0 : d;
        q <= rst ? 1'b0 : meta_q;
    end
endmodule
`default_nettype wire

// ### core/fip_chunk_guard.sv
// Per-16KB chunk lookup in a pair of protection masks
`include "fip_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fip_chunk_guard (
    input wire logic clk,
    input wire logic rst,
    input wire logic check_valid,
    input wire logic [19:0] addr,
    input wire logic [31:0] mask_low,
    input wire logic [31:0] mask_high,
    output var logic result_valid,
    output var logic locked
);
    function automatic logic chunk_open(input logic [31:0] mask,
                                        input logic [4:0] idx);
        chunk_open = mask[idx];
    endfunction
    wire logic [4:0] idx = addr[`FIP_CHUNK_HI:`FIP_CHUNK_LO];
    wire logic open_low = chunk_open(mask_low, idx);
    wire logic open_high = chunk_open(mask_high, idx);
    // Cleared bit locks the chunk; address bit 19 picks the half
    wire logic lock_d = addr[`FIP_ADDR_HALF] ? ~open_high : ~open_low;
    always_ff @(posedge clk)
    begin
        result_valid <= rst ? 1'b0 : check_valid;
        locked <= rst ? 1'b0 : (check_valid & lock_d);
    end
endmodule
`default_nettype wire

// ### core/fip_top.sv
// Customer info page decoder: shadow words, locks, wipe sequencing
`include "fip_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fip_top #(
    // Arbitrary value, stands for a valid page signature
    parameter logic [127:0] SIGNATURE_VALUE =
        128'h0123456789abcdef_0f1e2d3c4b5a6978
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output var logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    input wire logic info_load_valid,
    input wire logic [3:0] info_load_index,
    input wire logic [31:0] info_load_data,
    output logic [127:0] page_signature,
    output var logic signature_match,
    output logic boot_loop_select,
    output logic trace_output_allow,
    output var logic debug_port_allow,
    output logic [9:0] mem_rail_trim,
    output logic [9:0] core_rail_trim,
    input wire logic info_erase_req,
    output var logic info_erase_grant,
    output var logic info_erase_refuse,
    input wire logic info_prog_req,
    input wire logic [12:0] info_prog_addr,
    output var logic info_prog_grant,
    output var logic info_prog_refuse,
    input wire logic prog_check_valid,
    input wire logic [19:0] prog_check_addr,
    output logic prog_result_valid,
    output logic prog_locked,
    input wire logic read_check_valid,
    input wire logic [19:0] read_check_addr,
    output logic read_result_valid,
    output logic read_locked,
    input wire logic debugger_attached,
    output logic flash_wipe_req,
    input wire logic flash_wipe_ack,
    output logic sram_wipe_req,
    input wire logic sram_wipe_ack
);
    logic [31:0] word_q [0:15];
    logic freeze_q;
    logic dbg_sync;
    logic dbg_prev_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    fip_pkg::fip_wipe_state_t state_q;
    fip_pkg::fip_wipe_state_t state_d;

    function automatic logic idx_mapped(input logic [3:0] idx);
        idx_mapped = (idx <= `FIP_IDX_TRIM) || idx == `FIP_IDX_WPL ||
            idx == `FIP_IDX_WPH || idx == `FIP_IDX_CPL ||
            idx == `FIP_IDX_CPH;
    endfunction

    // Shadow words of the info page, loaded by the flash controller
    wire logic load_en = info_load_valid & ~freeze_q;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_word
            wire logic hit = load_en && info_load_index == 4'(gi) &&
                idx_mapped(4'(gi));
            always_ff @(posedge clk)
            begin
                if (rst)
                    word_q[gi] <= `FIP_WORD_RESET;
                else if (hit)
                    word_q[gi] <= info_load_data;
            end
        end
    endgenerate

    wire logic [31:0] sec = word_q[`FIP_IDX_SEC];
    wire logic [31:0] trim = word_q[`FIP_IDX_TRIM];

    assign page_signature = {word_q[`FIP_IDX_SIGNATURE_HIGH_BITS],
        word_q[`FIP_IDX_SIG2], word_q[`FIP_IDX_SIG1],
        word_q[`FIP_IDX_SIGNATURE_LOW_BITS]};
    assign boot_loop_select = sec[`FIP_SEC_BOOT];
    assign trace_output_allow = sec[`FIP_SEC_TRACE];
    assign mem_rail_trim = trim[`FIP_TRIM_MEM_HI:`FIP_TRIM_MEM_LO];
    assign core_rail_trim = trim[`FIP_TRIM_CORE_HI:`FIP_TRIM_CORE_LO];

    // Info page erase and program permission, one cycle after request
    wire logic [1:0] qtr = info_prog_addr[`FIP_QTR_HI:`FIP_QTR_LO];
    wire logic [3:0] prog_bits = sec[`FIP_SEC_PROG_HI:`FIP_SEC_PROG_LO];
    wire logic erase_ok = sec[`FIP_SEC_ERASE];
    wire logic prog_ok = prog_bits[qtr];
    always_ff @(posedge clk)
    begin
        info_erase_grant <= ~rst & info_erase_req & erase_ok;
        info_erase_refuse <= ~rst & info_erase_req & ~erase_ok;
        info_prog_grant <= ~rst & info_prog_req & prog_ok;
        info_prog_refuse <= ~rst & info_prog_req & ~prog_ok;
        signature_match <= ~rst && page_signature == SIGNATURE_VALUE;
    end

    // Flash program and readout chunk locks
    fip_chunk_guard u_prog_guard (
        .clk(clk),
        .rst(rst),
        .check_valid(prog_check_valid),
        .addr(prog_check_addr),
        .mask_low(word_q[`FIP_IDX_WPL]),
        .mask_high(word_q[`FIP_IDX_WPH]),
        .result_valid(prog_result_valid),
        .locked(prog_locked)
    );
    fip_chunk_guard u_read_guard (
        .clk(clk),
        .rst(rst),
        .check_valid(read_check_valid),
        .addr(read_check_addr),
        .mask_low(word_q[`FIP_IDX_CPL]),
        .mask_high(word_q[`FIP_IDX_CPH]),
        .result_valid(read_result_valid),
        .locked(read_locked)
    );

    // Debugger attach detection and wipe sequencing
    fip_sync2 u_dbg_sync (
        .clk(clk),
        .rst(rst),
        .d(debugger_attached),
        .q(dbg_sync)
    );
    wire logic attach = dbg_sync & ~dbg_prev_q;
    wire logic need_fwipe = ~sec[`FIP_SEC_FWIPE];
    wire logic need_swipe = ~sec[`FIP_SEC_SWIPE];
    wire logic wiping = state_q == fip_pkg::WIPE_FLASH ||
        state_q == fip_pkg::WIPE_SRAM;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            fip_pkg::WIPE_IDLE:
                if (attach)
                    state_d = need_fwipe ? fip_pkg::WIPE_FLASH :
                        need_swipe ? fip_pkg::WIPE_SRAM :
                        fip_pkg::WIPE_DONE;
            fip_pkg::WIPE_FLASH:
                if (flash_wipe_ack)
                    state_d = need_swipe ? fip_pkg::WIPE_SRAM :
                        fip_pkg::WIPE_DONE;
            fip_pkg::WIPE_SRAM:
                if (sram_wipe_ack)
                    state_d = fip_pkg::WIPE_DONE;
            fip_pkg::WIPE_DONE:
                if (!dbg_sync)
                    state_d = fip_pkg::WIPE_IDLE;
            default:
                state_d = fip_pkg::WIPE_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        state_q <= rst ? fip_pkg::WIPE_IDLE : state_d;
        dbg_prev_q <= rst ? 1'b0 : dbg_sync;
        // Debug is shut from one cycle after a wipe starts to one cycle after it ends
        debug_port_allow <= ~rst & sec[`FIP_SEC_DEBUG] & ~wiping;
    end
    assign flash_wipe_req = state_q == fip_pkg::WIPE_FLASH;
    assign sram_wipe_req = state_q == fip_pkg::WIPE_SRAM;

    // AXI4-Lite slave
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire logic do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire logic ctrl_hit = awaddr_q == `FIP_OFF_CTRL;
    wire logic [3:0] rd_idx = s_axi_araddr[`FIP_AIDX_HI:`FIP_AIDX_LO];
    // Aligned, inside the low 64 bytes and one of the mapped words
    wire logic rd_word = s_axi_araddr == {2'h0, rd_idx, 2'h0} &&
        idx_mapped(rd_idx);
    wire logic rd_ctrl = s_axi_araddr == `FIP_OFF_CTRL;
    wire logic rd_stat = s_axi_araddr == `FIP_OFF_STAT;
    wire logic [31:0] stat_word = {26'h0, state_q, dbg_sync,
        signature_match, wiping};
    wire logic [31:0] rd_data = rd_word ? word_q[rd_idx] :
        rd_ctrl ? {31'h0, freeze_q} : rd_stat ? stat_word : 32'h0;
    wire logic rd_ok = rd_word | rd_ctrl | rd_stat;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FIP_RESP_OKAY;
            freeze_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= ctrl_hit ? `FIP_RESP_OKAY : `FIP_RESP_SLVERR;
                if (ctrl_hit && wstrb_q[0])
                    freeze_q <= wdata_q[`FIP_CTRL_FREEZE];
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FIP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? `FIP_RESP_OKAY : `FIP_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Chunk indices seen by the lock checks below
    wire logic [4:0] prog_chunk = prog_check_addr[`FIP_CHUNK_HI:`FIP_CHUNK_LO];
    wire logic [4:0] read_chunk = read_check_addr[`FIP_CHUNK_HI:`FIP_CHUNK_LO];

    sequence s_attach_idle;
        attach && state_q == fip_pkg::WIPE_IDLE;
    endsequence
    sequence s_flash_done;
        flash_wipe_req && flash_wipe_ack;
    endsequence

    a_sig_high_word: assert property (
        load_en && info_load_index == `FIP_IDX_SIGNATURE_HIGH_BITS |=>
        page_signature[127:96] == $past(info_load_data))
        else $error("signature high word not loaded");
    a_boot_select: assert property (
        load_en && info_load_index == `FIP_IDX_SEC |=>
        boot_loop_select == $past(info_load_data[`FIP_SEC_BOOT]))
        else $error("boot loop select wrong");
    a_erase_refuse: assert property (
        info_erase_req && !sec[`FIP_SEC_ERASE] |=>
        info_erase_refuse && !info_erase_grant)
        else $error("info erase not refused");
    a_erase_grant: assert property (
        info_erase_req && sec[`FIP_SEC_ERASE] |=>
        info_erase_grant && !info_erase_refuse)
        else $error("info erase not granted");
    a_prog_quarter: assert property (
        info_prog_req |=> info_prog_grant == $past(prog_bits[qtr]) &&
        info_prog_refuse != info_prog_grant)
        else $error("info program quarter gate wrong");
    a_flash_wipe_start: assert property (
        s_attach_idle ##0 need_fwipe |=> flash_wipe_req ##1 !debug_port_allow)
        else $error("flash wipe not started");
    a_flash_wipe_hold: assert property (
        flash_wipe_req && !flash_wipe_ack |=> flash_wipe_req)
        else $error("flash wipe request dropped");
    a_sram_direct: assert property (
        s_attach_idle ##0 !need_fwipe ##0 need_swipe |=> sram_wipe_req)
        else $error("sram wipe skipped");
    a_sram_after_flash: assert property (
        s_flash_done ##0 need_swipe |=> sram_wipe_req && !flash_wipe_req)
        else $error("sram wipe not started");
    a_trace_off: assert property (
        !sec[`FIP_SEC_TRACE] |-> !trace_output_allow)
        else $error("trace output enabled");
    a_debug_off: assert property (
        !sec[`FIP_SEC_DEBUG] ##1 !sec[`FIP_SEC_DEBUG] |-> !debug_port_allow)
        else $error("debug port enabled");
    a_trim_fields: assert property (
        load_en && info_load_index == `FIP_IDX_TRIM |=>
        mem_rail_trim ==
        $past(info_load_data[`FIP_TRIM_MEM_HI:`FIP_TRIM_MEM_LO]) &&
        core_rail_trim ==
        $past(info_load_data[`FIP_TRIM_CORE_HI:`FIP_TRIM_CORE_LO]))
        else $error("trim fields wrong");
    a_prog_chunk_lock: assert property (
        prog_check_valid && !prog_check_addr[`FIP_ADDR_HALF] &&
        !word_q[`FIP_IDX_WPL][prog_chunk] |=>
        prog_result_valid && prog_locked)
        else $error("program chunk not locked");
    a_read_chunk_lock: assert property (
        read_check_valid && read_check_addr[`FIP_ADDR_HALF] |=>
        read_locked == !$past(word_q[`FIP_IDX_CPH][read_chunk]))
        else $error("readout chunk lock wrong");
endmodule
`default_nettype wire

// ### test/fip_far_model.sv
// Behavioural flash controller that answers wipe requests
`timescale 1ns/100ps
`default_nettype none
module fip_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] ack_delay,
    input wire logic flash_wipe_req,
    output var logic flash_wipe_ack,
    input wire logic sram_wipe_req,
    output var logic sram_wipe_ack
);
    logic [3:0] f_cnt_q, s_cnt_q;
    // One ack pulse after ack_delay + 1 cycles of a standing request
    always_ff @(posedge clk)
    begin
        flash_wipe_ack <= 1'b0;
        sram_wipe_ack <= 1'b0;
        f_cnt_q <= 4'h0;
        s_cnt_q <= 4'h0;
        if (!rst && flash_wipe_req && !flash_wipe_ack)
        begin
            f_cnt_q <= f_cnt_q + 4'h1;
            flash_wipe_ack <= (f_cnt_q == ack_delay);
        end
        if (!rst && sram_wipe_req && !sram_wipe_ack)
        begin
            s_cnt_q <= s_cnt_q + 4'h1;
            sram_wipe_ack <= (s_cnt_q == ack_delay);
        end
    end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the info page decoder
`include "fip_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [127:0] SIG_VAL =
        128'h5a5a1234_c3c39876_0f0f4321_a5a56789;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, info_load_valid, signature_match;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, info_load_data;
    logic [3:0] s_axi_wstrb, info_load_index, ack_delay;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [127:0] page_signature;
    logic boot_loop_select, trace_output_allow, debug_port_allow;
    logic [9:0] mem_rail_trim, core_rail_trim;
    logic info_erase_req, info_erase_grant, info_erase_refuse;
    logic info_prog_req, info_prog_grant, info_prog_refuse;
    logic [12:0] info_prog_addr;
    logic prog_check_valid, prog_result_valid, prog_locked;
    logic read_check_valid, read_result_valid, read_locked;
    logic [19:0] prog_check_addr, read_check_addr;
    logic debugger_attached, flash_wipe_req, flash_wipe_ack;
    logic sram_wipe_req, sram_wipe_ack, frozen;
    int bad_count, total_checks, fw_rises, sw_rises;
    logic [31:0] sh [16];
    int idx_list [10] = '{0, 1, 2, 3, 4, 5, 8, 9, 12, 13};

    fip_top #(.SIGNATURE_VALUE(SIG_VAL)) i_fip_top (.clk, .rst,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .info_load_valid, .info_load_index, .info_load_data,
        .page_signature, .signature_match, .boot_loop_select,
        .trace_output_allow, .debug_port_allow, .mem_rail_trim,
        .core_rail_trim, .info_erase_req, .info_erase_grant,
        .info_erase_refuse, .info_prog_req, .info_prog_addr,
        .info_prog_grant, .info_prog_refuse, .prog_check_valid,
        .prog_check_addr, .prog_result_valid, .prog_locked,
        .read_check_valid, .read_check_addr, .read_result_valid,
        .read_locked, .debugger_attached, .flash_wipe_req,
        .flash_wipe_ack, .sram_wipe_req, .sram_wipe_ack);
    fip_far_model i_fip_far_model (.clk, .rst, .ack_delay, .flash_wipe_req,
        .flash_wipe_ack, .sram_wipe_req, .sram_wipe_ack);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if ($rose(flash_wipe_req))
            fw_rises <= fw_rises + 1;
        if ($rose(sram_wipe_req))
            sw_rises <= sw_rises + 1;
    end

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask

    function automatic logic open_bit(input logic [31:0] lo,
        input logic [31:0] hi, input logic [19:0] a);
        logic [31:0] m;
        m = a[19] ? hi : lo;
        return m[a[18:14]];
    endfunction

    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ap, wp;
        ap = 1'b1;
        wp = 1'b1;
        r = 2'h3;
        @(posedge clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (ap && s_axi_awready)
            begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wp && s_axi_wready)
            begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d);
        logic ap;
        ap = 1'b1;
        r = 2'h3;
        d = 32'h0;
        @(posedge clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (ap && s_axi_arready)
            begin
                ap = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        s_axi_rready <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic [31:0] d;
        axi_rd(a, d);
        chk_word(d, e);
        chk_word({30'h0, r}, {30'h0, er});
    endtask

    task load(input int idx, input logic [31:0] d);
        @(posedge clk);
        info_load_valid <= 1'b1;
        info_load_index <= 4'(idx);
        info_load_data <= d;
        @(posedge clk);
        info_load_valid <= 1'b0;
        if (!frozen)
            sh[idx] = d;
    endtask

    task check_all;
        for (int k = 0; k < 10; k++)
            rd_chk(8'(4 * idx_list[k]), sh[idx_list[k]],
                `FIP_RESP_OKAY);
        for (int k = 0; k < 4; k++)
            chk_word(page_signature[32 * k +: 32], sh[k]);
        chk_bit(signature_match,
            {sh[3], sh[2], sh[1], sh[0]} == SIG_VAL);
        chk_bit(boot_loop_select, sh[4][9]);
        chk_bit(trace_output_allow, sh[4][1]);
        chk_bit(debug_port_allow, sh[4][0]);
        chk_word({22'h0, mem_rail_trim}, {22'h0, sh[5][25:16]});
        chk_word({22'h0, core_rail_trim}, {22'h0, sh[5][9:0]});
    endtask

    // Back-to-back random requests on all four lock ports
    task pipe_run(input int n);
        logic e [64], p [64], c [64], v [64];
        logic [12:0] pa [64];
        logic [19:0] ca [64], va [64];
        logic q;
        for (int i = 0; i < n + 2; i++)
        begin
            @(posedge clk);
            if (i >= 2)
            begin
                q = sh[4][4 + pa[i - 2][12:11]];
                chk_bit(info_erase_grant, e[i - 2] & sh[4][8]);
                chk_bit(info_erase_refuse, e[i - 2] & ~sh[4][8]);
                chk_bit(info_prog_grant, p[i - 2] & q);
                chk_bit(info_prog_refuse, p[i - 2] & ~q);
                chk_bit(prog_result_valid, c[i - 2]);
                chk_bit(prog_locked, c[i - 2] &
                    ~open_bit(sh[8], sh[9], ca[i - 2]));
                chk_bit(read_result_valid, v[i - 2]);
                chk_bit(read_locked, v[i - 2] &
                    ~open_bit(sh[12], sh[13], va[i - 2]));
            end
            {e[i], p[i], c[i], v[i]} = (i < n) ? 4'($urandom) : 4'h0;
            pa[i] = 13'($urandom);
            ca[i] = 20'($urandom);
            va[i] = 20'($urandom);
            info_erase_req <= e[i];
            info_prog_req <= p[i];
            info_prog_addr <= pa[i];
            prog_check_valid <= c[i];
            prog_check_addr <= ca[i];
            read_check_valid <= v[i];
            read_check_addr <= va[i];
        end
    endtask

    task wipe_run(input logic [1:0] b);
        int f0, s0;
        logic [31:0] d;
        load(4, {sh[4][31:4], b, sh[4][1:0]});
        ack_delay <= 4'($urandom);
        f0 = fw_rises;
        s0 = sw_rises;
        debugger_attached <= 1'b1;
        d = 32'h0;
        for (int n = 0; n < 40 && d[5:3] != 3'h3; n++)
            axi_rd(`FIP_OFF_STAT, d);
        chk_word({29'h0, d[5:3]}, 32'h3);
        chk_word(32'(fw_rises - f0), {31'h0, ~b[1]});
        chk_word(32'(sw_rises - s0), {31'h0, ~b[0]});
        debugger_attached <= 1'b0;
        for (int n = 0; n < 40 && d[5:3] != 3'h0; n++)
            axi_rd(`FIP_OFF_STAT, d);
        chk_word({29'h0, d[5:3]}, 32'h0);
        chk_bit(debug_port_allow, sh[4][0]);
    endtask

    // Whole run is under a thousand cycles; this is forty times that
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end

    initial
    begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, info_load_valid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {info_load_index, info_load_data, ack_delay} = 40'h0;
        s_axi_wstrb = 4'hf;
        {info_erase_req, info_prog_req, info_prog_addr} = 15'h0;
        {prog_check_valid, prog_check_addr} = 21'h0;
        {read_check_valid, read_check_addr, debugger_attached} = 22'h0;
        frozen = 1'b0;
        void'($urandom(32'hd456));
        for (int k = 0; k < 16; k++)
            sh[k] = `FIP_WORD_RESET;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        check_all();
        rd_chk(8'h18, 32'h0, `FIP_RESP_SLVERR);
        rd_chk(8'h02, 32'h0, `FIP_RESP_SLVERR);
        axi_wr(`FIP_OFF_SEC, 32'h0);
        chk_word({30'h0, r}, {30'h0, `FIP_RESP_SLVERR});
        rd_chk(`FIP_OFF_SEC, sh[4], `FIP_RESP_OKAY);
        $display("test reset_and_map done");
        for (int t = 0; t < 4; t++)
        begin
            for (int k = 0; k < 10; k++)
                load(idx_list[k], $urandom);
            for (int k = 0; k < 4 && t == 3; k++)
                load(k, SIG_VAL[32 * k +: 32]);
            check_all();
            pipe_run(48);
            $display("test decode round %0d done", t);
        end
        axi_wr(`FIP_OFF_CTRL, 32'h1);
        chk_word({30'h0, r}, {30'h0, `FIP_RESP_OKAY});
        frozen = 1'b1;
        load(4, $urandom);
        rd_chk(`FIP_OFF_SEC, sh[4], `FIP_RESP_OKAY);
        rd_chk(`FIP_OFF_CTRL, 32'h1, `FIP_RESP_OKAY);
        axi_wr(`FIP_OFF_CTRL, 32'h0);
        chk_word({30'h0, r}, {30'h0, `FIP_RESP_OKAY});
        frozen = 1'b0;
        $display("test freeze done");
        for (int b = 0; b < 4; b++)
            wipe_run(2'(b));
        $display("test wipe done");
        test_done();
    end
endmodule
`default_nettype wire
